// ---- rtl/rtc_core.sv ----
/*
 * rtc_core: interrupt control/status, BCD timekeeping with leap years,
 * alarm flag and the active-low open-drain interrupt output.
 * Assumes the serial bus engine presents byte writes and a read address
 * synchronous to mclk; countdown timer and alarm settings come in as ports.
 */
// Summary of operation
// - control/status bits 7..5 always read zero and cannot be written.
// - level mode: interrupt active while timer flag and timer enable set.
// - pulse mode: each timer event gives one enabled pulse, width by source.
// - pulse mode with alarm flag and alarm enable holds interrupt active.
// - an alarm event sets the alarm flag, bit 3.
// - end of timer countdown sets the timer flag, bit 2.
// - both flags stay set until a host write clears them.
// - written flag bits are ANDed with current value; 0 clears, 1 keeps.
// - each enable lets its flag drive interrupt; result is OR of both.
// - loaded value zero means timer stopped; width depends on n=1 or more for 4096 Hz and 64 Hz sources.
// - seconds bit 7 shows clock integrity lost.
// - seconds are BCD 00..59 in bits 6..0.
// - minutes are BCD 00..59 in bits 6..0; bit 7 unused.
// - hours are BCD 00..23 in bits 5..0; bits 7..6 unused.
// - day of month is BCD 01..31 in bits 5..0.
// - February has 29 days when year divisible by 4, year 00 included.
// - weekday is binary 0..6 in bits 2..0; upper bits unused.
// - century bit toggles when year wraps from 99 to 00.
// - alarm occurs when all enabled comparisons first match current time.
`timescale 1ns/1ps
`default_nettype none
module rtc_core
    import rtc_pkg::*;
#(
    parameter int OSC_PER_SEC  = OSC_HZ,
    parameter int PULSE_N1_4K  = PULSE_CYC_8192,
    parameter int PULSE_NX_4K  = PULSE_CYC_4096,
    parameter int PULSE_N1_64  = PULSE_CYC_128,
    parameter int PULSE_SLOW   = PULSE_CYC_64
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       oscTick,
    input  wire logic       supplyLow,
    input  wire rtc_alarm_t alarmCfg,
    input  wire rtc_timer_t timerIn,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    output logic            irqOut,
    output logic            irqOe
);
    generate
        if (OSC_PER_SEC < 2 || OSC_PER_SEC > 65536) begin : g_bad_osc
            $error("OSC_PER_SEC out of range");
        end
        if (PULSE_N1_4K < 1 || PULSE_NX_4K < 1 || PULSE_N1_64 < 1 || PULSE_SLOW < 1 ||
            PULSE_N1_4K >= (1 << PCNT_W) || PULSE_NX_4K >= (1 << PCNT_W) ||
            PULSE_N1_64 >= (1 << PCNT_W) || PULSE_SLOW >= (1 << PCNT_W)) begin : g_bad_pulse
            $error("pulse width parameter out of range");
        end
    endgenerate

    logic [15:0]       presc_ff;
    logic              secTick;
    rtc_time_t         time_ff;
    rtc_time_t         nxt_time;
    logic              integrityLost_ff;
    logic              pulseSel_ff;
    logic              alarmFlag_ff;
    logic              timerFlag_ff;
    logic              alarmIe_ff;
    logic              timerIe_ff;
    logic              nxt_alarmFlag;
    logic              nxt_timerFlag;
    logic              nxt_pulseSel;
    logic              nxt_alarmIe;
    logic              nxt_timerIe;
    logic [PCNT_W-1:0] pulseCnt_ff;
    logic [PCNT_W-1:0] nxt_pulseCnt;
    logic              alarmMatch;
    logic              alarmMatchPrev_ff;
    logic              alarmEvent;
    logic              timerSet;
    logic              pulseLoad;
    logic              csWrite;
    logic [7:0]        regRdData_ff;
    logic              irqOe_ff;
    logic              irqOut_ff;

    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcdInc

    // year is BCD: tens parity decides which units make it a multiple of 4
    function automatic logic isLeap(input logic [7:0] y);
        if (y[4]) begin
            return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction : isLeap

    function automatic logic [7:0] lastDay(input logic [7:0] m, input logic [7:0] y);
        unique case (m)
            8'h02:                      return isLeap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction : lastDay

    function automatic logic [PCNT_W-1:0] pulseWidth(input rtc_tsrc_t s,
                                                     input logic      n1);
        unique case (s)
            TSRC_4096: return n1 ? PCNT_W'(PULSE_N1_4K) : PCNT_W'(PULSE_NX_4K);
            TSRC_64:   return n1 ? PCNT_W'(PULSE_N1_64) : PCNT_W'(PULSE_SLOW);
            default:   return PCNT_W'(PULSE_SLOW);
        endcase
    endfunction : pulseWidth

    // one-second enable from the oscillator tick
    assign secTick = oscTick && (presc_ff == 16'(OSC_PER_SEC - 1));

    always_ff @(posedge mclk) begin
        if (rst) begin
            presc_ff <= 16'h0000;
        end else if (secTick) begin
            presc_ff <= 16'h0000;
        end else if (oscTick) begin
            presc_ff <= presc_ff + 16'h0001;
        end
    end

    always_comb begin
        nxt_time = time_ff;
        if (secTick) begin
            if (time_ff.sec == MAX_SEC) begin
                nxt_time.sec = RST_ZERO;
                if (time_ff.min == MAX_SEC) begin
                    nxt_time.min = RST_ZERO;
                    if (time_ff.hour == MAX_HOUR) begin
                        nxt_time.hour = RST_ZERO;
                        nxt_time.wday = (time_ff.wday == MAX_WDAY) ? RST_ZERO
                                                                   : time_ff.wday + 8'h01;
                        if (time_ff.day == lastDay(time_ff.month, time_ff.year)) begin
                            nxt_time.day = FIRST_DAY;
                            if (time_ff.month == MAX_MON) begin
                                nxt_time.month = FIRST_DAY;
                                if (time_ff.year == MAX_YEAR) begin
                                    nxt_time.year    = RST_ZERO;
                                    nxt_time.century = ~time_ff.century;
                                end else begin
                                    nxt_time.year = bcdInc(time_ff.year);
                                end
                            end else begin
                                nxt_time.month = bcdInc(time_ff.month);
                            end
                        end else begin
                            nxt_time.day = bcdInc(time_ff.day);
                        end
                    end else begin
                        nxt_time.hour = bcdInc(time_ff.hour);
                    end
                end else begin
                    nxt_time.min = bcdInc(time_ff.min);
                end
            end else begin
                nxt_time.sec = bcdInc(time_ff.sec);
            end
        end
        // a host write to a field wins over the carry into it
        if (regWrEn) begin
            unique case (regAddr)
                ADDR_SECONDS:  nxt_time.sec   = regWrData & MASK_SEC;
                ADDR_MINUTES:  nxt_time.min   = regWrData & MASK_MIN;
                ADDR_HOURS:    nxt_time.hour  = regWrData & MASK_HOUR;
                ADDR_DAYS:     nxt_time.day   = regWrData & MASK_DAY;
                ADDR_WEEKDAYS: nxt_time.wday  = regWrData & MASK_WDAY;
                ADDR_MONTHS: begin
                    nxt_time.month   = regWrData & MASK_MON;
                    nxt_time.century = regWrData[MON_CENTURY];
                end
                ADDR_YEARS:    nxt_time.year  = regWrData;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            time_ff <= '{sec: RST_ZERO, min: RST_ZERO, hour: RST_ZERO,
                         day: FIRST_DAY, wday: RST_ZERO, month: FIRST_DAY,
                         year: RST_ZERO, century: 1'b0};
        end else begin
            time_ff <= nxt_time;
        end
    end

    // power-on leaves time unreliable until software rewrites it
    always_ff @(posedge mclk) begin
        if (rst) begin
            integrityLost_ff <= 1'b1;
        end else if (supplyLow) begin
            integrityLost_ff <= 1'b1;
        end else if (regWrEn && regAddr == ADDR_SECONDS) begin
            integrityLost_ff <= regWrData[SEC_INTEGRITY];
        end
    end

    // disabled fields count as matching; with all disabled no alarm fires
    always_comb begin
        alarmMatch = !(alarmCfg.minDis && alarmCfg.hourDis &&
                       alarmCfg.dayDis && alarmCfg.wdayDis);
        if (!alarmCfg.minDis && alarmCfg.minute != time_ff.min[6:0]) begin
            alarmMatch = 1'b0;
        end
        if (!alarmCfg.hourDis && alarmCfg.hour != time_ff.hour[5:0]) begin
            alarmMatch = 1'b0;
        end
        if (!alarmCfg.dayDis && alarmCfg.day != time_ff.day[5:0]) begin
            alarmMatch = 1'b0;
        end
        if (!alarmCfg.wdayDis && alarmCfg.wday != time_ff.wday[2:0]) begin
            alarmMatch = 1'b0;
        end
    end

    // only the first cycle of a match counts, so a cleared flag stays clear
    assign alarmEvent = alarmMatch && !alarmMatchPrev_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            alarmMatchPrev_ff <= 1'b1;
        end else begin
            alarmMatchPrev_ff <= alarmMatch;
        end
    end

    assign csWrite   = regWrEn && (regAddr == ADDR_CTRL_STATUS);
    assign timerSet  = timerIn.done && (timerIn.reload != 8'h00);
    assign pulseLoad = timerSet && nxt_pulseSel && nxt_timerIe;

    always_comb begin
        nxt_pulseSel  = pulseSel_ff;
        nxt_alarmIe   = alarmIe_ff;
        nxt_timerIe   = timerIe_ff;
        nxt_alarmFlag = alarmFlag_ff;
        nxt_timerFlag = timerFlag_ff;
        if (csWrite) begin
            nxt_pulseSel  = regWrData[CS_PULSE_SEL];
            nxt_alarmIe   = regWrData[CS_ALARM_IE];
            nxt_timerIe   = regWrData[CS_TIMER_IE];
            nxt_alarmFlag = alarmFlag_ff & regWrData[CS_ALARM_FLAG];
            nxt_timerFlag = timerFlag_ff & regWrData[CS_TIMER_FLAG];
        end
        // setting wins over a clear in the same cycle
        nxt_alarmFlag = nxt_alarmFlag | alarmEvent;
        nxt_timerFlag = nxt_timerFlag | timerSet;
    end

    // own process: pulseLoad is derived from the next values above
    always_comb begin
        if (pulseLoad) begin
            nxt_pulseCnt = pulseWidth(timerIn.src, timerIn.reload == 8'h01);
        end else if (pulseCnt_ff != '0) begin
            nxt_pulseCnt = pulseCnt_ff - PCNT_W'(1);
        end else begin
            nxt_pulseCnt = pulseCnt_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pulseSel_ff  <= 1'b0;
            alarmIe_ff   <= 1'b0;
            timerIe_ff   <= 1'b0;
            alarmFlag_ff <= 1'b0;
            timerFlag_ff <= 1'b0;
            pulseCnt_ff  <= '0;
        end else begin
            pulseSel_ff  <= nxt_pulseSel;
            alarmIe_ff   <= nxt_alarmIe;
            timerIe_ff   <= nxt_timerIe;
            alarmFlag_ff <= nxt_alarmFlag;
            timerFlag_ff <= nxt_timerFlag;
            pulseCnt_ff  <= nxt_pulseCnt;
        end
    end

    // built from next values so the pin and the timer flag move together
    always_ff @(posedge mclk) begin
        if (rst) begin
            irqOe_ff  <= 1'b0;
            irqOut_ff <= 1'b0;
        end else begin
            irqOe_ff  <= (nxt_alarmFlag && nxt_alarmIe) ||
                         (nxt_timerIe && (nxt_pulseSel ? (nxt_pulseCnt != '0)
                                                       : nxt_timerFlag));
            irqOut_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdData_ff <= 8'h00;
        end else begin
            unique case (regAddr)
                ADDR_CTRL_STATUS: regRdData_ff <= {3'b000, pulseSel_ff, alarmFlag_ff,
                                                   timerFlag_ff, alarmIe_ff, timerIe_ff};
                ADDR_SECONDS:  regRdData_ff <= {integrityLost_ff, time_ff.sec[6:0]};
                ADDR_MINUTES:  regRdData_ff <= time_ff.min & MASK_MIN;
                ADDR_HOURS:    regRdData_ff <= time_ff.hour & MASK_HOUR;
                ADDR_DAYS:     regRdData_ff <= time_ff.day & MASK_DAY;
                ADDR_WEEKDAYS: regRdData_ff <= time_ff.wday & MASK_WDAY;
                ADDR_MONTHS:   regRdData_ff <= {time_ff.century, time_ff.month[6:0]};
                ADDR_YEARS:    regRdData_ff <= time_ff.year;
                default:       regRdData_ff <= 8'h00;
            endcase
        end
    end

    assign regRdData = regRdData_ff;
    assign irqOe     = irqOe_ff;
    assign irqOut    = irqOut_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_upper_zero: assert property (
        (regAddr == ADDR_CTRL_STATUS) |=> (regRdData[7:5] == 3'b000))
        else $error("control/status upper bits not zero");
    a_level_irq: assert property (
        (!pulseSel_ff && timerIe_ff && timerFlag_ff) |-> irqOe)
        else $error("level interrupt missing");
    a_pulse_width: assert property (
        (pulseLoad && timerIn.src == TSRC_4096 && timerIn.reload == 8'h01)
        |=> (pulseCnt_ff == PCNT_W'(PULSE_N1_4K)) && timerFlag_ff && irqOe)
        else $error("pulse width wrong");
    a_alarm_hold: assert property (
        (pulseSel_ff && alarmFlag_ff && alarmIe_ff) |-> irqOe)
        else $error("alarm does not hold interrupt");
    a_alarm_set: assert property (
        alarmEvent |=> alarmFlag_ff ##1 (regRdData[CS_ALARM_FLAG] ||
                                         $past(regAddr) != ADDR_CTRL_STATUS))
        else $error("alarm flag not set");
    a_timer_set: assert property (
        timerSet |=> timerFlag_ff && (irqOe || !timerIe_ff))
        else $error("timer flag not set with interrupt");
    a_flag_sticky: assert property (
        (alarmFlag_ff && !(csWrite && !regWrData[CS_ALARM_FLAG])) |=> alarmFlag_ff)
        else $error("alarm flag lost without write");
    a_flag_and: assert property (
        (csWrite && !timerSet)
        |=> (timerFlag_ff == ($past(timerFlag_ff) && $past(regWrData[CS_TIMER_FLAG])))
            && (alarmFlag_ff == (($past(alarmFlag_ff) && $past(regWrData[CS_ALARM_FLAG]))
                                 || $past(alarmEvent))))
        else $error("flag write not ANDed");
    a_irq_quiet: assert property (
        (!alarmIe_ff && !timerIe_ff) |-> !irqOe)
        else $error("interrupt without enable");
    a_timer_stopped: assert property (
        (timerIn.done && timerIn.reload == 8'h00 && !timerFlag_ff && !csWrite)
        |=> !timerFlag_ff)
        else $error("stopped timer set flag");
    a_sec_wrap: assert property (
        (secTick && time_ff.sec == MAX_SEC && !regWrEn) |=> time_ff.sec == RST_ZERO)
        else $error("seconds did not wrap");
endmodule : rtc_core
`default_nettype wire

// ---- rtl/rtc_pkg.sv ----
/*
 * rtc_pkg: register map, field positions, reset values, types and
 * timing counts for the clock/calendar core.
 * Assumes a 250 MHz mclk and a 32.768 kHz oscillator tick enable.
 */
package rtc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h01;
    localparam logic [7:0] ADDR_SECONDS     = 8'h02;
    localparam logic [7:0] ADDR_MINUTES     = 8'h03;
    localparam logic [7:0] ADDR_HOURS       = 8'h04;
    localparam logic [7:0] ADDR_DAYS        = 8'h05;
    localparam logic [7:0] ADDR_WEEKDAYS    = 8'h06;
    localparam logic [7:0] ADDR_MONTHS      = 8'h07;
    localparam logic [7:0] ADDR_YEARS       = 8'h08;
    // control/status, seconds and months field bits
    localparam int CS_PULSE_SEL  = 4;
    localparam int CS_ALARM_FLAG = 3;
    localparam int CS_TIMER_FLAG = 2;
    localparam int CS_ALARM_IE   = 1;
    localparam int CS_TIMER_IE   = 0;
    localparam int SEC_INTEGRITY = 7;
    localparam int MON_CENTURY   = 7;
    // implemented-bit masks
    localparam logic [7:0] MASK_CS   = 8'h1f;
    localparam logic [7:0] MASK_SEC  = 8'h7f;
    localparam logic [7:0] MASK_MIN  = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h3f;
    localparam logic [7:0] MASK_DAY  = 8'h3f;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_MON  = 8'h1f;
    // BCD limits and reset values
    localparam logic [7:0] MAX_SEC   = 8'h59;
    localparam logic [7:0] MAX_HOUR  = 8'h23;
    localparam logic [7:0] MAX_WDAY  = 8'h06;
    localparam logic [7:0] MAX_MON   = 8'h12;
    localparam logic [7:0] MAX_YEAR  = 8'h99;
    localparam logic [7:0] FIRST_DAY = 8'h01;
    localparam logic [7:0] RST_ZERO  = 8'h00;
    // timing
    localparam int CLK_HZ        = 250_000_000;
    localparam int OSC_HZ        = 32768;
    localparam int PULSE_DEN_8192 = 8192;
    localparam int PULSE_DEN_4096 = 4096;
    localparam int PULSE_DEN_128  = 128;
    localparam int PULSE_DEN_64   = 64;
    localparam int PULSE_CYC_8192 = CLK_HZ / PULSE_DEN_8192;
    localparam int PULSE_CYC_4096 = CLK_HZ / PULSE_DEN_4096;
    localparam int PULSE_CYC_128  = CLK_HZ / PULSE_DEN_128;
    localparam int PULSE_CYC_64   = CLK_HZ / PULSE_DEN_64;
    localparam int PCNT_W         = 22;

    typedef enum logic [1:0] {
        TSRC_4096 = 2'h0,
        TSRC_64   = 2'h1,
        TSRC_1HZ  = 2'h2,
        TSRC_1_60 = 2'h3
    } rtc_tsrc_t;

    typedef struct packed {
        logic       minDis;
        logic [6:0] minute;
        logic       hourDis;
        logic [5:0] hour;
        logic       dayDis;
        logic [5:0] day;
        logic       wdayDis;
        logic [2:0] wday;
    } rtc_alarm_t;

    typedef struct packed {
        rtc_tsrc_t  src;
        logic [7:0] reload;
        logic       done;
    } rtc_timer_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
        logic [7:0] wday;
        logic [7:0] month;
        logic [7:0] year;
        logic       century;
    } rtc_time_t;
endpackage : rtc_pkg

// ---- verification/rtc_host_model.sv ----
/*
 * rtc_host_model: register-port host standing in for the serial bus engine;
 * byte writes and reads through tasks called by the bench.
 * Assumes one mclk domain; requests change 1 ns after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] regRdData,
    output var  logic       regWrEn,
    output var  logic [7:0] regAddr,
    output var  logic [7:0] regWrData
);
    initial begin
        regWrEn   = 1'b0;
        regAddr   = 8'h0F;
        regWrData = 8'h00;
    end

    // strobe lasts exactly one edge; data goes stale afterwards, not held
    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(posedge mclk) #1;
        regWrEn   = 1'b0;
        regWrData = ~d;
    endtask : wrReg

    // read data is registered: valid after the edge that samples the address
    task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        regAddr = a;
        @(posedge mclk) #1;
        d = regRdData;
    endtask : rdReg
endmodule : rtc_host_model
`default_nettype wire

// ---- verification/rtc_irq_status_and_time_regs_bench.sv ----
/*
 * rtc_irq_status_and_time_regs_bench: directed register and interrupt tests
 * of rtc_core with shortened second and pulse counts.
 * Assumes rtc_pkg, rtc_core and rtc_host_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_status_and_time_regs_bench
    import rtc_pkg::*;
;
    localparam int OSC_N = 4;
    localparam int P1 = 3;
    localparam int P2 = 5;
    localparam int P3 = 7;
    localparam int P4 = 9;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       oscTick = 1'b0;
    logic       supplyLow = 1'b0;
    rtc_alarm_t alarmCfg = '{1'b1, 7'h00, 1'b1, 6'h00, 1'b1, 6'h00, 1'b1, 3'h0};
    rtc_timer_t timerIn = '{TSRC_4096, 8'h00, 1'b0};
    logic       regWrEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       irqOut;
    logic       irqOe;
    wire        irqLine = irqOe ? irqOut : 1'b1; // pulled up when released
    int         errors = 0;
    int         check_count = 0;
    rtc_tsrc_t  srcTab [6] = '{TSRC_4096, TSRC_4096, TSRC_64, TSRC_64, TSRC_1HZ, TSRC_1_60};
    int         nTab [6] = '{1, 5, 1, 5, 1, 5};
    int         wTab [6] = '{P1, P2, P3, P4, P4, P4};

    initial forever #2 mclk = ~mclk;

    rtc_core #(.OSC_PER_SEC(OSC_N), .PULSE_N1_4K(P1), .PULSE_NX_4K(P2),
        .PULSE_N1_64(P3), .PULSE_SLOW(P4)) i_rtc_core (
        .mclk(mclk), .rst(rst), .oscTick(oscTick), .supplyLow(supplyLow),
        .alarmCfg(alarmCfg), .timerIn(timerIn), .regWrEn(regWrEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .irqOut(irqOut), .irqOe(irqOe));

    rtc_host_model i_rtc_host_model (.mclk(mclk), .regRdData(regRdData),
        .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData));

    task automatic summarize;
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_rtc_host_model.rdReg(a, d);
        cmp(d, exp);
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_rtc_host_model.wrReg(a, d);
    endtask : wr

    task automatic tickSec;
        repeat (OSC_N) begin
            @(posedge mclk) #1 oscTick = 1'b1;
            @(posedge mclk) #1 oscTick = 1'b0;
        end
    endtask : tickSec

    task automatic timerDone(input rtc_tsrc_t s, input logic [7:0] n);
        @(posedge mclk) #1 timerIn = '{s, n, 1'b1};
        @(posedge mclk) #1 timerIn.done = 1'b0;
    endtask : timerDone

    // one second from 23:59:59 on the given date, then the whole date back
    task automatic calStep(input logic [7:0] d, w, mo, y, ed, ew, emo, ey);
        wr(ADDR_SECONDS, 8'h59);
        wr(ADDR_MINUTES, 8'h59);
        wr(ADDR_HOURS, 8'h23);
        wr(ADDR_DAYS, d);
        wr(ADDR_WEEKDAYS, w);
        wr(ADDR_MONTHS, mo);
        wr(ADDR_YEARS, y);
        tickSec();
        chk(ADDR_SECONDS, 8'h00);
        chk(ADDR_MINUTES, 8'h00);
        chk(ADDR_HOURS, 8'h00);
        chk(ADDR_DAYS, ed);
        chk(ADDR_WEEKDAYS, ew);
        chk(ADDR_MONTHS, emo);
        chk(ADDR_YEARS, ey);
    endtask : calStep

    initial begin
        int cnt;
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        chk(ADDR_CTRL_STATUS, 8'h00);
        chk(ADDR_SECONDS, 8'h80);
        chk(ADDR_DAYS, 8'h01);
        chk(8'h0F, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'hFF);
        chk(ADDR_CTRL_STATUS, 8'h13);
        // level mode, timer only
        wr(ADDR_CTRL_STATUS, 8'h01);
        timerDone(TSRC_64, 8'h05);
        repeat (20) @(posedge mclk);
        cmp({7'h00, irqLine}, 8'h00);
        chk(ADDR_CTRL_STATUS, 8'h05);
        wr(ADDR_CTRL_STATUS, 8'h09);
        chk(ADDR_CTRL_STATUS, 8'h01);
        cmp({7'h00, irqLine}, 8'h01);
        timerDone(TSRC_4096, 8'h00);
        chk(ADDR_CTRL_STATUS, 8'h01);
        // pulse widths by source and reload
        wr(ADDR_CTRL_STATUS, 8'h11);
        for (int i = 0; i < 6; i++) begin
            timerDone(srcTab[i], nTab[i][7:0]);
            cnt = 0;
            while (irqOe === 1'b1 && cnt < 100) begin
                cnt++;
                @(posedge mclk) #1;
            end
            if (cnt == 100) begin
                errors++;
                summarize();
            end
            cmp(cnt[7:0], wTab[i][7:0]);
            chk(ADDR_CTRL_STATUS, 8'h15);
            wr(ADDR_CTRL_STATUS, 8'h11);
        end
        // calendar rollovers: leap Feb, plain Feb, 30-day month, century
        calStep(8'h28, 8'h06, 8'h02, 8'h00, 8'h29, 8'h00, 8'h02, 8'h00);
        calStep(8'h28, 8'h03, 8'h02, 8'h01, 8'h01, 8'h04, 8'h03, 8'h01);
        calStep(8'h28, 8'h00, 8'h02, 8'h12, 8'h29, 8'h01, 8'h02, 8'h12);
        calStep(8'h28, 8'h04, 8'h02, 8'h10, 8'h01, 8'h05, 8'h03, 8'h10);
        calStep(8'h30, 8'h01, 8'h04, 8'h07, 8'h01, 8'h02, 8'h05, 8'h07);
        calStep(8'h31, 8'h02, 8'h12, 8'h99, 8'h01, 8'h03, 8'h81, 8'h00);
        @(posedge mclk) #1 supplyLow = 1'b1;
        @(posedge mclk) #1 supplyLow = 1'b0;
        chk(ADDR_SECONDS, 8'h80);
        // alarm on minute 01 in pulse mode holds the line
        wr(ADDR_CTRL_STATUS, 8'h12);
        alarmCfg = '{1'b0, 7'h01, 1'b1, 6'h00, 1'b1, 6'h00, 1'b1, 3'h0};
        wr(ADDR_SECONDS, 8'h59);
        tickSec();
        chk(ADDR_CTRL_STATUS, 8'h1A);
        repeat (20) @(posedge mclk);
        cmp({7'h00, irqLine}, 8'h00);
        wr(ADDR_CTRL_STATUS, 8'h12);
        chk(ADDR_CTRL_STATUS, 8'h12);
        cmp({7'h00, irqLine}, 8'h01);
        summarize();
    end
endmodule : rtc_irq_status_and_time_regs_bench
`default_nettype wire
